// [src/adc_conv_regs.svh]
// Purpose: Offsets, field ranges, reset values and timing counts of the conversion control block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef ADC_CONV_REGS_SVH
`define ADC_CONV_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_CTRL    5'h00
`define OFS_CHPOS   5'h04
`define OFS_CHNEG   5'h08
`define OFS_STAT    5'h0C
`define OFS_RESULT  5'h10
`define OFS_SWRST   5'h14

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define CTRL_TYPE   2:0
`define CTRL_MODE   4:3
`define CTRL_EN     5
`define CTRL_DIV    13:8
`define CTRL_ACQ    20:16
`define CTRL_MASK   32'h001F3F3F
`define CTRL_RST    32'h00080200

// ---------------------------------------------------------------
// Status and result fields
// ---------------------------------------------------------------
`define STAT_READY  0
`define STAT_BUSY   1
`define RES_FIELD   27:16
`define RES_SIGN    31:28

// ---------------------------------------------------------------
// Channels and timing counts
// ---------------------------------------------------------------
`define CH_RST      5'h00
`define CH_TEMP     5'h10
`define DIV_ONE     6'h01
`define DIV_TEMP    6'h20
`define ACQ_ONE     5'h01
`define ACQ_TEMP    5'h10
`define BIT_MSB     4'hB
`define BIT_LSB     4'h0
`define BIT_STEP    4'h1
`define CODE_MID    12'h800
`define CODE_ZERO   12'h000

`endif

// [src/adc_conv_pkg.sv]
// Purpose: Types shared by the conversion control block
// Assumes: Used by scoped reference only
// Notes:   Mode 3 is unused and codes as single-ended
package adc_conv_pkg;

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_ACQ   = 4'h2,
      ST_TRIAL = 4'h4,
      ST_WRITE = 4'h8
   } state_t;

   // ---------------------------------------------------------------
   // Conversion start sources
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CT_NONE   = 3'h0,
      CT_SINGLE = 3'h1,
      CT_CONT   = 3'h2,
      CT_PIN    = 3'h3,
      CT_LOGIC  = 3'h4,
      CT_TMR0   = 3'h5,
      CT_TMR1   = 3'h6
   } conv_type_t;

   // ---------------------------------------------------------------
   // Input configurations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MD_DIFF   = 2'h0,
      MD_SINGLE = 2'h1,
      MD_PSEUDO = 2'h2
   } mode_t;

endpackage : adc_conv_pkg

// [src/adc_conversion_control.sv]
// Purpose: Start, sequence and format successive-approximation conversions
// Assumes: Comparator and mux are analog macros on clk; trigger levels other than the pin are on clk
// Notes:   One wait state on every bus access
//
// Notes on behaviour
// - Three input configurations (differential, single-ended, pseudo differential) set pairing and coding.
// - Software may start one conversion or a continuous run that restarts until software stops it.
// - The start pin, the logic array output or either timer overflow may trigger conversions instead.
// - A trigger level still high when a conversion completes starts another at once.
// - A temperature channel is selectable on the multiplexer; as the positive input it forces divider 32 and acquisition count 16.
// - Single-ended and pseudo differential results are unsigned straight binary.
// - The sequencer can reach one million samples per second from the full-speed clock.
// - Each conversion resolves 12 bits by one trial per bit, most significant first.
// - A ready bit at position zero sets at conversion end and clears when the result is read.
// - The conversion-active pin is high for the whole of each conversion.
// - The result sits in bits 16 to 27 with the top four bits as sign extension.
// - Differential results are two's complement shifted right by one.
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "adc_conv_regs.svh"

module adc_conversion_control #(
   parameter int RES_BITS = 12,
   parameter int CH_BITS  = 5
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   input  wire logic        conversion_start_pin,
   input  wire logic        logic_array_output,
   input  wire logic        timer_zero_overflow,
   input  wire logic        timer_one_overflow,
   input  wire logic        cmp_above,
   output      logic        conversion_active_pin,
   output      logic        conversion_done_flag,
   output      logic        track,
   output      logic [11:0] dac_code,
   output      logic [4:0]  mux_pos,
   output      logic [4:0]  mux_neg,
   output      logic [1:0]  input_mode,
   output      logic        adc_enable
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   // Result layout and channel codes are fixed by the register map
   if (RES_BITS != 12 || CH_BITS != 5) begin : g_bad_params
      $error("adc_conversion_control supports RES_BITS 12 and CH_BITS 5 only");
   end

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   adc_conv_pkg::state_t     st;
   adc_conv_pkg::conv_type_t ctype;
   adc_conv_pkg::mode_t      mode;
   logic        ack;
   logic        req;
   logic        acc_wr;
   logic        acc_rd;
   logic [31:0] ctrl;
   logic [4:0]  chp;
   logic [4:0]  chn;
   logic        ready;
   logic [11:0] res;
   logic        res_sign;
   logic [31:0] next_rdata;
   logic        pin_meta;
   logic        pin_sync;
   logic        trig_level;
   logic        trig_prev;
   logic        trig_edge;
   logic        pending;
   logic        single_req;
   logic        start;
   logic        en;
   logic        is_temp;
   logic [5:0]  eff_div;
   logic [4:0]  eff_acq;
   logic [5:0]  divcnt;
   logic        tick;
   logic [4:0]  acqcnt;
   logic [3:0]  bitidx;
   logic [11:0] code;
   logic        done;
   logic        swrst;
   logic [11:0] twos;
   logic [11:0] next_res;
   logic        next_sign;

   // ---------------------------------------------------------------
   // Byte-lane merge
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   // Read data is captured in the wait cycle so it stands as a flop
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack;
   assign acc_wr          = avs_write & ack;
   assign acc_rd          = avs_read & ack;
   assign swrst           = acc_wr && avs_address == `OFS_SWRST;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   always_comb begin
      case (avs_address)
         `OFS_CTRL:   next_rdata = ctrl;
         `OFS_CHPOS:  next_rdata = {27'h0000000, chp};
         `OFS_CHNEG:  next_rdata = {27'h0000000, chn};
         `OFS_STAT:   next_rdata = {30'h00000000, conversion_active_pin, ready};
         `OFS_RESULT: next_rdata = {{4{res_sign}}, res, 16'h0000};
         default:     next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack) begin
         avs_readdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst || swrst) begin
         ctrl <= `CTRL_RST;
         chp  <= `CH_RST;
         chn  <= `CH_RST;
      end else if (acc_wr) begin
         if (avs_address == `OFS_CTRL) begin
            ctrl <= merge(ctrl, avs_writedata, avs_byteenable) & `CTRL_MASK;
         end
         if (avs_address == `OFS_CHPOS && avs_byteenable[0]) begin
            chp <= avs_writedata[4:0];
         end
         if (avs_address == `OFS_CHNEG && avs_byteenable[0]) begin
            chn <= avs_writedata[4:0];
         end
      end
   end

   assign ctype      = adc_conv_pkg::conv_type_t'(ctrl[`CTRL_TYPE]);
   assign mode       = adc_conv_pkg::mode_t'(ctrl[`CTRL_MODE]);
   assign en         = ctrl[`CTRL_EN];
   assign adc_enable = en;
   assign mux_pos    = chp;
   assign mux_neg    = chn;
   assign input_mode = ctrl[`CTRL_MODE];

   // ---------------------------------------------------------------
   // Trigger sources
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= conversion_start_pin;
         pin_sync <= pin_meta;
      end
   end

   always_comb begin
      case (ctype)
         adc_conv_pkg::CT_PIN:   trig_level = pin_sync;
         adc_conv_pkg::CT_LOGIC: trig_level = logic_array_output;
         adc_conv_pkg::CT_TMR0:  trig_level = timer_zero_overflow;
         adc_conv_pkg::CT_TMR1:  trig_level = timer_one_overflow;
         default:                trig_level = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         trig_prev <= 1'b0;
      end else begin
         trig_prev <= trig_level;
      end
   end

   assign trig_edge = trig_level & ~trig_prev;

   // Edges during a conversion are held back, never restart it
   always_ff @(posedge clk) begin
      if (!nrst || swrst || !en) begin
         pending <= 1'b0;
      end else if (done && trig_level) begin
         pending <= 1'b1;
      end else if (trig_edge && st != adc_conv_pkg::ST_IDLE) begin
         pending <= 1'b1;
      end else if (start) begin
         pending <= 1'b0;
      end
   end

   // A write of the single type arms exactly one conversion
   // Arming wins over the disable clear so one write may enable and start together
   always_ff @(posedge clk) begin
      if (!nrst || swrst) begin
         single_req <= 1'b0;
      end else if (acc_wr && avs_address == `OFS_CTRL && avs_byteenable[0]
                   && avs_writedata[`CTRL_TYPE] == adc_conv_pkg::CT_SINGLE) begin
         single_req <= 1'b1;
      end else if (start || !en) begin
         single_req <= 1'b0;
      end
   end

   assign start = st == adc_conv_pkg::ST_IDLE && en
                  && (single_req || pending || trig_edge
                      || ctype == adc_conv_pkg::CT_CONT);

   // ---------------------------------------------------------------
   // Conversion clock
   // ---------------------------------------------------------------
   // A divider of one with acquisition count 8 gives 21 active cycles, 22 per sample in continuous runs, fast enough for full rate
   assign is_temp = chp == `CH_TEMP;
   assign eff_div = is_temp ? `DIV_TEMP :
                    (ctrl[`CTRL_DIV] == 6'h00) ? `DIV_ONE : ctrl[`CTRL_DIV];
   assign eff_acq = is_temp ? `ACQ_TEMP :
                    (ctrl[`CTRL_ACQ] == 5'h00) ? `ACQ_ONE : ctrl[`CTRL_ACQ];
   assign tick    = divcnt == eff_div - `DIV_ONE;

   always_ff @(posedge clk) begin
      if (!nrst || start || tick || st == adc_conv_pkg::ST_IDLE) begin
         divcnt <= 6'h00;
      end else begin
         divcnt <= divcnt + `DIV_ONE;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   assign done = st == adc_conv_pkg::ST_WRITE && tick;

   always_ff @(posedge clk) begin
      if (!nrst || swrst || !en) begin
         st <= adc_conv_pkg::ST_IDLE;
      end else begin
         case (st)
            adc_conv_pkg::ST_IDLE: begin
               if (start) begin
                  st <= adc_conv_pkg::ST_ACQ;
               end
            end
            adc_conv_pkg::ST_ACQ: begin
               if (tick && acqcnt == eff_acq - `ACQ_ONE) begin
                  st <= adc_conv_pkg::ST_TRIAL;
               end
            end
            adc_conv_pkg::ST_TRIAL: begin
               if (tick && bitidx == `BIT_LSB) begin
                  st <= adc_conv_pkg::ST_WRITE;
               end
            end
            adc_conv_pkg::ST_WRITE: begin
               if (tick) begin
                  st <= adc_conv_pkg::ST_IDLE;
               end
            end
            default: st <= adc_conv_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || st != adc_conv_pkg::ST_ACQ) begin
         acqcnt <= 5'h00;
      end else if (tick) begin
         acqcnt <= acqcnt + `ACQ_ONE;
      end
   end

   // One trial per tick, the comparator keeps or drops the bit on trial
   always_ff @(posedge clk) begin
      if (!nrst) begin
         code   <= `CODE_ZERO;
         bitidx <= `BIT_MSB;
      end else if (st == adc_conv_pkg::ST_ACQ) begin
         code   <= `CODE_MID;
         bitidx <= `BIT_MSB;
      end else if (st == adc_conv_pkg::ST_TRIAL && tick) begin
         code[bitidx] <= cmp_above;
         if (bitidx != `BIT_LSB) begin
            code[bitidx - `BIT_STEP] <= 1'b1;
            bitidx <= bitidx - `BIT_STEP;
         end
      end
   end

   assign conversion_active_pin = st != adc_conv_pkg::ST_IDLE;
   assign track                 = st == adc_conv_pkg::ST_ACQ;
   assign dac_code              = code;

   // ---------------------------------------------------------------
   // Result formatting
   // ---------------------------------------------------------------
   // Offset code to two's complement, then halve keeping the sign
   assign twos = {~code[11], code[10:0]};

   always_comb begin
      if (mode == adc_conv_pkg::MD_DIFF) begin
         next_res  = {twos[11], twos[11:1]};
         next_sign = twos[11];
      end else begin
         next_res  = code;
         next_sign = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         res      <= `CODE_ZERO;
         res_sign <= 1'b0;
      end else if (done) begin
         res      <= next_res;
         res_sign <= next_sign;
      end
   end

   // ---------------------------------------------------------------
   // Ready flag
   // ---------------------------------------------------------------
   // A completion in the read cycle keeps the flag set
   always_ff @(posedge clk) begin
      if (!nrst || swrst) begin
         ready <= 1'b0;
      end else if (done) begin
         ready <= 1'b1;
      end else if (acc_rd && avs_address == `OFS_RESULT) begin
         ready <= 1'b0;
      end
   end

   assign conversion_done_flag = ready;

endmodule : adc_conversion_control

// [tb/adc_conv_properties.sv]
// Purpose: Port-level checks of the conversion control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Software reset and disable aborts are not checked here
`timescale 1ns/1ps
`include "adc_conv_regs.svh"
module adc_conv_checker #(
   parameter int RES_BITS = 12,
   parameter int CH_BITS  = 5
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        conversion_start_pin,
   input wire logic        conversion_active_pin,
   input wire logic        conversion_done_flag,
   input wire logic        track,
   input wire logic [11:0] dac_code,
   input wire logic [1:0]  input_mode
);
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   wire logic rd_res = avs_read && !avs_waitrequest && avs_address == `OFS_RESULT;
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   property p_one_wait;
      $rose(avs_read || avs_write) |-> s_one_wait;
   endproperty
   property p_track_start;
      $rose(conversion_active_pin) |-> track;
   endproperty
   property p_done_end;
      $fell(conversion_active_pin) |-> conversion_done_flag;
   endproperty
   property p_first_trial;
      $fell(track) && conversion_active_pin |-> dac_code == `CODE_MID;
   endproperty
   property p_no_retrack;
      conversion_active_pin && !track |=> !track;
   endproperty
   property p_clear;
      rd_res && !conversion_active_pin |=> !conversion_done_flag;
   endproperty
   property p_hold;
      conversion_done_flag && !avs_write && !rd_res |=> conversion_done_flag;
   endproperty
   property p_format;
      rd_res |-> avs_readdata[15:0] == 16'h0000
         && avs_readdata[31:28] == (input_mode == 2'h0 ? {4{avs_readdata[27]}} : 4'h0);
   endproperty
   // Two flops plus edge detect: a start may not show within two cycles
   property p_sync;
      !conversion_active_pin && $rose(conversion_start_pin) |-> ##2 !conversion_active_pin;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
   a_track_start: assert property (p_track_start) else $error("no acquisition at start");
   a_done_end: assert property (p_done_end) else $error("ready not set at end");
   a_first_trial: assert property (p_first_trial) else $error("first trial not mid code");
   a_no_retrack: assert property (p_no_retrack) else $error("conversion restarted");
   a_clear: assert property (p_clear) else $error("ready not cleared by read");
   a_hold: assert property (p_hold) else $error("ready lost");
   a_format: assert property (p_format) else $error("result format wrong");
   a_sync: assert property (p_sync) else $error("start pin not synchronised");
endmodule : adc_conv_checker

bind adc_conversion_control adc_conv_checker #(.RES_BITS(RES_BITS), .CH_BITS(CH_BITS)) u_chk (
   .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conversion_start_pin(conversion_start_pin),
   .conversion_active_pin(conversion_active_pin), .conversion_done_flag(conversion_done_flag),
   .track(track), .dac_code(dac_code), .input_mode(input_mode));

// [tb/trigger_partner.sv]
// Purpose: Comparator and timer overflow sources beside the block
// Assumes: All on clk
// Notes:   A long period models a slow timer
`timescale 1ns/1ps
module trigger_partner (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [11:0] dac_code,
   input  wire logic [11:0] vin_code,
   input  wire logic [1:0]  tmr_run,
   output      logic        cmp_above,
   output      logic        timer_zero_overflow,
   output      logic        timer_one_overflow
);
   logic [7:0] tick;
   // Ideal comparator, so the trials alone decide the code
   assign cmp_above = vin_code >= dac_code;
   always_ff @(posedge clk) begin
      tick <= nrst ? tick + 8'h01 : 8'h00;
   end
   // One-cycle overflow pulses every 256 cycles
   always_ff @(posedge clk) begin
      timer_zero_overflow <= nrst && tmr_run[0] && tick == 8'hFF;
      timer_one_overflow  <= nrst && tmr_run[1] && tick == 8'hFF;
   end
endmodule : trigger_partner

// [tb/tb_adc_conversion_control.sv]
// Purpose: Self-checking bench of the conversion control block
// Assumes: One wait state per access, default and fast timing settings
// Notes:   Expected codes follow the ideal comparator of the partner
`timescale 1ns/1ps
`include "adc_conv_regs.svh"
module tb_adc_conversion_control;
   logic        clk, nrst, avs_read, avs_write, avs_waitrequest, cmp_above, track, adc_enable;
   logic        conversion_start_pin, logic_array_output, timer_zero_overflow, timer_one_overflow;
   logic        conversion_active_pin, conversion_done_flag;
   logic [4:0]  avs_address, mux_pos, mux_neg;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable;
   logic [11:0] dac_code, vin_code;
   logic [1:0]  input_mode, tmr_run;
   int          n_fail, n_tests, len, gap;
   adc_conversion_control DUT (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conversion_start_pin(conversion_start_pin),
      .logic_array_output(logic_array_output), .timer_zero_overflow(timer_zero_overflow),
      .timer_one_overflow(timer_one_overflow), .cmp_above(cmp_above), .conversion_active_pin(conversion_active_pin),
      .conversion_done_flag(conversion_done_flag), .track(track), .dac_code(dac_code), .mux_pos(mux_pos),
      .mux_neg(mux_neg), .input_mode(input_mode), .adc_enable(adc_enable));
   trigger_partner u_far (.clk(clk), .nrst(nrst), .dac_code(dac_code), .vin_code(vin_code), .tmr_run(tmr_run),
      .cmp_above(cmp_above), .timer_zero_overflow(timer_zero_overflow), .timer_one_overflow(timer_one_overflow));
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'h1;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      avs_write <= 1'h0;
      @(posedge clk);
   endtask : bus_wr
   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'h1;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      d = avs_readdata;
      avs_read <= 1'h0;
      @(posedge clk);
   endtask : bus_rd
   function automatic logic [31:0] ctrl(input logic [2:0] ty, input logic [1:0] md, input logic [5:0] dv,
                                        input logic [4:0] aq);
      return {11'h000, aq, 2'h0, dv, 2'h0, 1'h1, md, ty};
   endfunction : ctrl
   task automatic conv_len(output int n);
      n = 0;
      while (conversion_active_pin !== 1'h1) @(posedge clk);
      while (conversion_active_pin === 1'h1) begin
         n++;
         @(posedge clk);
      end
   endtask : conv_len
   task automatic idle_len(output int g);
      g = 0;
      while (conversion_active_pin !== 1'h1 && g < 50) begin
         g++;
         @(posedge clk);
      end
   endtask : idle_len
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_regs;
      bus_rd(`OFS_CTRL, rd);
      check("ctrl reset", rd, `CTRL_RST);
      bus_rd(`OFS_STAT, rd);
      check("stat reset", rd, 32'h00000000);
      bus_wr(`OFS_CTRL, 32'hFFFFFFF8);
      bus_rd(`OFS_CTRL, rd);
      check("ctrl mask", rd, 32'h001F3F38);
      check("mode out", input_mode, 2'h3);
      check("enable out", adc_enable, 1'h1);
      bus_wr(`OFS_CHNEG, 32'h00000007);
      check("mux neg", mux_neg, 5'h07);
      bus_wr(`OFS_SWRST, 32'h00000000);
      bus_rd(`OFS_CTRL, rd);
      check("ctrl swrst", rd, `CTRL_RST);
      check("neg swrst", mux_neg, 5'h00);
      check("enable swrst", adc_enable, 1'h0);
      bus_rd(5'h18, rd);
      check("unmapped", rd, 32'h00000000);
      $display("test regs done");
   endtask : t_regs
   task automatic t_temp;
      bus_wr(`OFS_CHPOS, {27'h0000000, `CH_TEMP});
      bus_wr(`OFS_CTRL, ctrl(3'h1, 2'h1, 6'h02, 5'h08));
      bus_rd(`OFS_STAT, rd);
      check("stat busy", rd, 32'h00000002);
      conv_len(len);
      check("temp len", len + 2, 928);
      $display("test temperature done");
   endtask : t_temp
   task automatic t_single(input logic [1:0] md, input logic [11:0] v, input logic [31:0] exp);
      vin_code <= v;
      bus_wr(`OFS_CHPOS, 32'h00000003);
      bus_wr(`OFS_CTRL, ctrl(3'h1, md, 6'h02, 5'h08));
      check("mode", input_mode, md);
      check("mux", mux_pos, 5'h03);
      conv_len(len);
      check("busy len", len, 42);
      bus_rd(`OFS_STAT, rd);
      check("ready set", rd, 32'h00000001);
      bus_rd(`OFS_RESULT, rd);
      check("result", rd, exp);
      bus_rd(`OFS_STAT, rd);
      check("ready clear", rd, 32'h00000000);
      $display("test single done");
   endtask : t_single
   task automatic t_cont;
      bus_wr(`OFS_CTRL, ctrl(3'h2, 2'h1, 6'h01, 5'h08));
      conv_len(len);
      idle_len(gap);
      check("cont len", len, 21);
      check("cont gap", gap < 3, 1'h1);
      bus_wr(`OFS_CTRL, ctrl(3'h0, 2'h1, 6'h01, 5'h08));
      repeat (30) @(posedge clk);
      check("cont stop", conversion_active_pin, 1'h0);
      bus_rd(`OFS_RESULT, rd);
      $display("test continuous done");
   endtask : t_cont
   task automatic t_trig(input logic [2:0] ty);
      vin_code <= 12'hFFF;
      bus_wr(`OFS_CTRL, ctrl(ty, 2'h2, 6'h01, 5'h01));
      case (ty)
         3'h3: conversion_start_pin <= 1'h1;
         3'h4: logic_array_output <= 1'h1;
         default: tmr_run <= ty[1:0];
      endcase
      @(posedge clk);
      conversion_start_pin <= 1'h0;
      logic_array_output <= 1'h0;
      conv_len(len);
      tmr_run <= 2'h0;
      check("trig len", len, 14);
      bus_rd(`OFS_RESULT, rd);
      check("trig result", rd, 32'h0FFF0000);
      $display("test trigger done");
   endtask : t_trig
   task automatic t_retrig;
      bus_wr(`OFS_CTRL, ctrl(3'h4, 2'h1, 6'h01, 5'h08));
      logic_array_output <= 1'h1;
      conv_len(len);
      idle_len(gap);
      check("level restart", gap < 4, 1'h1);
      len = 0;
      while (conversion_active_pin === 1'h1) begin
         len++;
         logic_array_output <= (len == 6);
         @(posedge clk);
      end
      check("retrig len", len, 21);
      idle_len(gap);
      check("pending start", gap < 4, 1'h1);
      conv_len(len);
      bus_rd(`OFS_RESULT, rd);
      $display("test retrigger done");
   endtask : t_retrig
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report;
   end
   initial begin
      {nrst, avs_read, avs_write, conversion_start_pin, logic_array_output} = 5'h00;
      {avs_address, avs_writedata, vin_code, tmr_run} = 51'h0;
      avs_byteenable = 4'hF;
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      t_regs;
      t_temp;
      t_single(2'h1, 12'hABC, 32'h0ABC0000);
      t_single(2'h0, 12'h234, 32'hFD1A0000);
      t_single(2'h0, 12'hC00, 32'h02000000);
      t_single(2'h2, 12'h000, 32'h00000000);
      t_cont;
      for (int t = 3; t < 7; t++) t_trig(t[2:0]);
      t_retrig;
      final_report;
   end
endmodule : tb_adc_conversion_control
